// >>> core/smr_defs.svh
`ifndef SMR_DEFS_SVH
`define SMR_DEFS_SVH
// ==========================================
// register byte offsets
`define SMR_OFF_CTRL 8'h00
`define SMR_OFF_BUF 8'h04
`define SMR_OFF_STAT 8'h08
`define SMR_OFF_CLR 8'h0C
`define SMR_OFF_IEN 8'h10
`define SMR_OFF_BAUD 8'h14
// ==========================================
// control register bit positions
`define SMR_CTRL_SEN 0
`define SMR_CTRL_STOP 2
`define SMR_CTRL_RECEIVE_ENABLE_BIT 3
`define SMR_CTRL_ACK_SEQUENCE_ENABLE 4
`define SMR_CTRL_ACK_VALUE_SELECT 5
`define SMR_CTRL_ACK_RECEIVED_STATUS 6
// ==========================================
// event status bit positions (status, clear, enable; full flag in status only)
`define SMR_EV_PIF 0
`define SMR_EV_OVF 1
`define SMR_EV_WRITE_COLLISION_FLAG 2
`define SMR_STAT_BF 3
// ==========================================
// reset values and timing
`define SMR_RST_BAUD 8'h18
`define SMR_RST_IEN 3'h0
`endif

// >>> core/smr_pkg.sv
package smr_pkg;
  typedef enum logic [2:0] {
    SMR_IDLE,
    SMR_START,
    SMR_TX,
    SMR_RX,
    SMR_ACK,
    SMR_STOP
  } smr_state_e;
endpackage : smr_pkg

// >>> core/smr_i2c_master_rx.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
`include "smr_defs.svh"
// Behaviour
// - receive enable accepted only while idle; otherwise the request is dropped
// - each baud rollover in a byte or ack toggles scl; every second one (scl falling) shifts sampled sda in
// - after eighth falling edge: clear receive enable, load buffer if full flag clear, set full and interrupt
// - after a byte: baud counter stops, scl held low, module idle
// - reading the data buffer clears the full flag
// - full flag set when address or data byte reaches the buffer
// - overflow set when a received byte completes while full flag still set
// - buffer write during reception sets collision flag, buffer unchanged
// - start enable generates a start, interrupt flag set when done
// - buffer write while idle sends the eight address bits at once
// - slave acknowledge after the address is stored as ack status
// - interrupt flag set at end of ninth address clock
// - ack enable clocks the selected ack value out, then sets interrupt
module smr_i2c_master_rx #(
  parameter logic [7:0] BAUD_RELOAD = `SMR_RST_BAUD
) (
  input wire logic sys_clk, // module clock, 20 MHz
  input wire logic resetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic irq, // level interrupt
  input wire logic scl_in, // scl pin level
  output logic scl_out, // scl drive value, always low
  output logic scl_oe, // scl pulled low while high
  input wire logic sda_in, // sda pin level
  output logic sda_out, // sda drive value, always low
  output logic sda_oe // sda pulled low while high
);
  // ==========================================
  // reset and pin synchronisers
  logic [1:0] rst_sync;
  logic rst_n;
  logic scl_m, scl_s, sda_m, sda_s;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end
    else
    begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
    end
  end

  // ==========================================
  // apb decode
  logic acc, wr, rd, hit;
  logic wr_ctrl, wr_buf, wr_clr, wr_ien, wr_baud, rd_buf;
  smr_pkg::smr_state_e state;
  logic tick, phase, scl_low, sda_low;
  logic [3:0] bit_cnt;
  logic [7:0] shift, buffer, baud, baud_cnt;
  logic bf, ack_value, ack_received;
  logic [2:0] stat, ien;
  logic start_done, tx_done, rx_done, ack_done, stop_done, last_fall;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign hit = paddr == `SMR_OFF_CTRL || paddr == `SMR_OFF_BUF || paddr == `SMR_OFF_STAT
            || paddr == `SMR_OFF_CLR || paddr == `SMR_OFF_IEN || paddr == `SMR_OFF_BAUD;
  assign wr_ctrl = wr && paddr == `SMR_OFF_CTRL;
  assign wr_buf = wr && paddr == `SMR_OFF_BUF;
  assign wr_clr = wr && paddr == `SMR_OFF_CLR;
  assign wr_ien = wr && paddr == `SMR_OFF_IEN;
  assign wr_baud = wr && paddr == `SMR_OFF_BAUD;
  assign rd_buf = rd && paddr == `SMR_OFF_BUF;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;

  // read data captured in the setup phase
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0;
      unique case (paddr)
        `SMR_OFF_CTRL: prdata[6:0] <= {ack_received, ack_value, 1'b0, state == smr_pkg::SMR_RX,
                                       state == smr_pkg::SMR_STOP, 1'b0, state == smr_pkg::SMR_START};
        `SMR_OFF_BUF: prdata[7:0] <= buffer;
        `SMR_OFF_STAT: prdata[3:0] <= {bf, stat};
        `SMR_OFF_IEN: prdata[2:0] <= ien;
        `SMR_OFF_BAUD: prdata[7:0] <= baud;
        default: prdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ien <= `SMR_RST_IEN;
      baud <= BAUD_RELOAD;
      ack_value <= 1'b0;
    end
    else
    begin
      if (wr_ien)
        ien <= pwdata[2:0];
      if (wr_baud)
        baud <= pwdata[7:0];
      if (wr_ctrl)
        ack_value <= pwdata[`SMR_CTRL_ACK_VALUE_SELECT];
    end
  end

  // ==========================================
  // baud rate generator, runs only outside idle
  assign tick = state != smr_pkg::SMR_IDLE && baud_cnt == 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      baud_cnt <= BAUD_RELOAD;
    else if (state == smr_pkg::SMR_IDLE || tick)
      baud_cnt <= baud;
    else
      baud_cnt <= baud_cnt - 8'h01;
  end

  // ==========================================
  // bus sequencer
  assign last_fall = tick && phase;
  assign start_done = state == smr_pkg::SMR_START && last_fall;
  assign tx_done = state == smr_pkg::SMR_TX && last_fall && bit_cnt == 4'h8;
  assign rx_done = state == smr_pkg::SMR_RX && last_fall && bit_cnt == 4'h7;
  assign ack_done = state == smr_pkg::SMR_ACK && last_fall;
  assign stop_done = state == smr_pkg::SMR_STOP && tick && bit_cnt == 4'h2;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= smr_pkg::SMR_IDLE;
      phase <= 1'b0;
      bit_cnt <= 4'h0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      shift <= 8'h00;
      ack_received <= 1'b0;
    end
    else
    begin
      unique case (state)
        smr_pkg::SMR_IDLE:
        begin
          phase <= 1'b0;
          bit_cnt <= 4'h0;
          if (wr_buf)
          begin
            state <= smr_pkg::SMR_TX;
            shift <= pwdata[7:0];
            sda_low <= !pwdata[7];
          end
          else if (wr_ctrl && pwdata[`SMR_CTRL_SEN])
            state <= smr_pkg::SMR_START;
          else if (wr_ctrl && pwdata[`SMR_CTRL_RECEIVE_ENABLE_BIT])
          begin
            state <= smr_pkg::SMR_RX;
            sda_low <= 1'b0;
          end
          else if (wr_ctrl && pwdata[`SMR_CTRL_ACK_SEQUENCE_ENABLE])
          begin
            state <= smr_pkg::SMR_ACK;
            sda_low <= !pwdata[`SMR_CTRL_ACK_VALUE_SELECT];
          end
          else if (wr_ctrl && pwdata[`SMR_CTRL_STOP])
            state <= smr_pkg::SMR_STOP;
        end
        smr_pkg::SMR_START:
          if (tick)
          begin
            phase <= 1'b1;
            if (!phase)
              sda_low <= 1'b1;
            else
            begin
              scl_low <= 1'b1;
              state <= smr_pkg::SMR_IDLE;
            end
          end
        smr_pkg::SMR_STOP:
          if (tick)
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h0)
              sda_low <= 1'b1;
            else if (bit_cnt == 4'h1)
              scl_low <= 1'b0;
            else
            begin
              sda_low <= 1'b0;
              state <= smr_pkg::SMR_IDLE;
            end
          end
        default:
          if (tick)
          begin
            phase <= !phase;
            scl_low <= phase;
            if (phase)
            begin
              shift <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
              if (state == smr_pkg::SMR_TX)
                sda_low <= bit_cnt < 4'h7 && !shift[6];
              if (tx_done)
                ack_received <= sda_s;
              if (tx_done || rx_done || ack_done)
              begin
                sda_low <= 1'b0;
                state <= smr_pkg::SMR_IDLE;
              end
            end
          end
      endcase
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_low;
  assign sda_oe = sda_low;

  // ==========================================
  // buffer, full flag and sticky events
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buffer <= 8'h00;
      bf <= 1'b0;
    end
    else
    begin
      if (rx_done && !bf)
        buffer <= {shift[6:0], sda_s};
      else if (tx_done)
        buffer <= shift;
      if (rx_done || tx_done)
        bf <= 1'b1;
      else if (rd_buf)
        bf <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      stat <= 3'h0;
    else
    begin
      stat[`SMR_EV_PIF] <= (start_done || tx_done || rx_done || ack_done || stop_done)
                           || (stat[`SMR_EV_PIF] && !(wr_clr && pwdata[`SMR_EV_PIF]));
      stat[`SMR_EV_OVF] <= (rx_done && bf)
                           || (stat[`SMR_EV_OVF] && !(wr_clr && pwdata[`SMR_EV_OVF]));
      stat[`SMR_EV_WRITE_COLLISION_FLAG] <= (wr_buf && state != smr_pkg::SMR_IDLE)
                            || (stat[`SMR_EV_WRITE_COLLISION_FLAG] && !(wr_clr && pwdata[`SMR_EV_WRITE_COLLISION_FLAG]));
    end
  end

  assign irq = |(stat & ien);

  // ==========================================
  // checks
  sequence byte_done_s;
    rx_done ##1 state == smr_pkg::SMR_IDLE;
  endsequence

  sequence held_low_s;
    scl_oe [*2];
  endsequence

  receive_enable_bit_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_ctrl && pwdata[`SMR_CTRL_RECEIVE_ENABLE_BIT] && state != smr_pkg::SMR_IDLE && state != smr_pkg::SMR_RX)
    |=> state != smr_pkg::SMR_RX)
    else $error("receive enable taken while busy");
  scl_toggle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == smr_pkg::SMR_RX && tick) |=> scl_oe != $past(scl_oe))
    else $error("scl did not toggle on rollover");
  byte_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rx_done && !bf) |=> (bf && stat[`SMR_EV_PIF] && buffer == $past({shift[6:0], sda_s})))
    else $error("received byte not loaded");
  scl_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    byte_done_s |-> held_low_s)
    else $error("scl not held low after byte");
  read_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd_buf && !rx_done && !tx_done) |=> !bf)
    else $error("buffer read did not clear full flag");
  full_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rx_done || tx_done) |=> bf)
    else $error("full flag not set on byte load");
  overflow_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rx_done && bf) |=> (stat[`SMR_EV_OVF] && $stable(buffer)))
    else $error("overflow not flagged or buffer overwritten");
  write_collide_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_buf && state == smr_pkg::SMR_RX && !rx_done) |=> (stat[`SMR_EV_WRITE_COLLISION_FLAG] && $stable(buffer)))
    else $error("collision not flagged");
  start_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start_done |=> (stat[`SMR_EV_PIF] && scl_oe && sda_oe))
    else $error("start completion not flagged");
  ack_stat_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_done |=> (ack_received == $past(sda_s) && stat[`SMR_EV_PIF]))
    else $error("slave ack not recorded");
  ack_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == smr_pkg::SMR_ACK && phase) |-> sda_oe == !ack_value)
    else $error("wrong ack level driven");
  scl_line_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!scl_oe) [*3] |-> scl_s)
    else $error("scl line not seen high once released");
  addr_send_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == smr_pkg::SMR_IDLE && wr_buf) |=> (state == smr_pkg::SMR_TX && sda_oe == !$past(pwdata[7])))
    else $error("address transfer not started");
endmodule : smr_i2c_master_rx

// >>> testbench/smr_slave_model.sv
`timescale 1ns/1ns
// ==========================================
// two-wire slave: acks its address, returns bytes
module smr_slave_model (
  input wire logic scl, // bus clock line
  input wire logic sda, // bus data line
  input wire logic [7:0] rd_byte, // byte returned on the next read
  output logic sda_low // pulls data line low
);
  int bitc;
  logic rx_data;
  logic active;
  initial
  begin
    bitc = 0;
    rx_data = 0;
    active = 0;
  end
  // start and stop are data edges while clock high
  // rechecked a moment later: a data change in the step scl falls is no condition
  always @(negedge sda)
    if (scl)
    begin
      #1;
      if (scl && !sda)
      begin
        active = 1;
        rx_data = 0;
        bitc = -1;
      end
    end
  always @(posedge sda)
    if (scl)
    begin
      #1;
      if (scl && sda)
        active = 0;
    end
  always @(negedge scl)
    if (active)
    begin
      bitc = bitc + 1;
      if (bitc == 9)
      begin
        bitc = 0;
        rx_data = 1;
      end
    end
  // a nack from the master ends the read
  always @(posedge scl)
    if (active && rx_data && bitc == 8 && sda)
      active = 0;
  assign sda_low = active && (rx_data ? (bitc < 8 && !rd_byte[7 - bitc]) : bitc == 8);
endmodule : smr_slave_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`include "smr_defs.svh"
module tb_top;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, irq, scl_oe, sda_oe, sda_low;
  logic scl_drv, sda_drv;
  logic [7:0] paddr, rd_byte;
  logic [31:0] pwdata, prdata, rd_last, seed;
  logic [65:0] exp_q[$];
  logic [65:0] note;
  logic [6:0] addr;
  logic [7:0] bv[3];
  int err_total, checks_done, cyc, k;
  wire scl = ~scl_oe;
  wire sda = ~(sda_oe | sda_low);
  smr_i2c_master_rx #(.BAUD_RELOAD(8'h01)) dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .scl_in(scl), .scl_out(scl_drv), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_drv),
    .sda_oe(sda_oe));
  smr_slave_model slave (.scl(scl), .sda(sda), .rd_byte(rd_byte), .sda_low(sda_low));
  // ==========================================
  // checking and closing
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task wrap_up;
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk)
    if (psel && penable && pready && !pwrite)
    begin
      note = exp_q.pop_front();
      rd_last = prdata;
      if (note[65])
        chk({pslverr, prdata & note[31:0]}, note[64:32]);
    end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      wrap_up;
    end
  end
  // ==========================================
  // apb master
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m, input logic en);
    exp_q.push_back({en, e, m});
    apb(0, a, 0);
  endtask : rd
  task wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 500)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 500)
      chk(0, 1);
  endtask : wait_irq
  // ==========================================
  // clock and main sequence
  initial
  begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    resetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    seed = $urandom(2);
    addr = 7'($urandom);
    foreach (bv[i]) bv[i] = 8'($urandom);
    rd_byte = bv[0];
    repeat (16) @(posedge sys_clk);
    resetn <= 1;
    repeat (3) @(posedge sys_clk);
    rd(`SMR_OFF_BAUD, 33'h01, 32'hFF, 1);
    rd(8'h40, {1'b1, 32'h0}, 32'h0, 1);
    chk({31'h0, scl_drv, sda_drv}, 33'h0);
    wr(`SMR_OFF_IEN, 32'h1);
    wr(`SMR_OFF_CTRL, 32'h1);
    wait_irq;
    rd(`SMR_OFF_STAT, 33'h1, 32'hF, 1);
    wr(`SMR_OFF_CLR, 32'h7);
    wr(`SMR_OFF_BUF, {24'h0, addr, 1'b1});
    wr(`SMR_OFF_CTRL, 32'h8);
    wait_irq;
    rd(`SMR_OFF_CTRL, 33'h0, 32'h48, 1);
    rd(`SMR_OFF_STAT, 33'h9, 32'hF, 1);
    wr(`SMR_OFF_IEN, 32'h0);
    chk({32'h0, irq}, 33'h0);
    wr(`SMR_OFF_IEN, 32'h1);
    chk({32'h0, irq}, 33'h1);
    rd(`SMR_OFF_BUF, {25'h0, addr, 1'b1}, 32'hFF, 1);
    rd(`SMR_OFF_STAT, 33'h1, 32'hF, 1);
    wr(`SMR_OFF_CLR, 32'h7);
    wr(`SMR_OFF_CTRL, 32'h8);
    wr(`SMR_OFF_BUF, 32'h55);
    wait_irq;
    repeat (8) @(posedge sys_clk);
    chk({32'h0, scl_oe}, 33'h1);
    rd(`SMR_OFF_CTRL, 33'h0, 32'h8, 1);
    rd(`SMR_OFF_STAT, 33'hD, 32'hF, 1);
    rd(`SMR_OFF_BUF, {25'h0, bv[0]}, 32'hFF, 1);
    // second byte is left unread so the third overflows
    for (k = 1; k < 3; k++)
    begin
      rd_byte <= bv[k];
      wr(`SMR_OFF_CLR, 32'h7);
      wr(`SMR_OFF_CTRL, 32'h10);
      wait_irq;
      rd(`SMR_OFF_STAT, 33'h1, 32'h1, 1);
      wr(`SMR_OFF_CLR, 32'h7);
      wr(`SMR_OFF_CTRL, 32'h8);
      wait_irq;
    end
    rd(`SMR_OFF_STAT, 33'hB, 32'hF, 1);
    rd(`SMR_OFF_BUF, {25'h0, bv[1]}, 32'hFF, 1);
    wr(`SMR_OFF_CLR, 32'h7);
    wr(`SMR_OFF_CTRL, 32'h30);
    wait_irq;
    wr(`SMR_OFF_CLR, 32'h7);
    wr(`SMR_OFF_CTRL, 32'h4);
    rd(`SMR_OFF_CTRL, 33'h0, 32'h0, 0);
    for (k = 0; k < 60 && rd_last[2]; k++)
      rd(`SMR_OFF_CTRL, 33'h0, 32'h0, 0);
    chk({30'h0, rd_last[2], scl, sda}, 33'h3);
    wrap_up;
  end
endmodule : tb_top
